// file: debounced_switch_input.sv
// Top of the debounced switch input with register port and interrupt
//
// The register addresses and strobed register access were decided locally.
module debounced_switch_input #(
  parameter int unsigned TICK_CYCLES = debounce_pkg::TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_pullup_en,
  output logic o_level,
  output logic o_irq
);
  debounce_core_if cif ();
  logic pin_meta;
  logic pin_sync;
  logic [16:0] tick_cnt;
  logic invert;
  logic [7:0] stable_ms;
  logic [15:0] trans_count;
  logic [31:0] duration_ms;
  logic [debounce_pkg::IRQ_W-1:0] irq_status;
  logic [debounce_pkg::IRQ_W-1:0] irq_mask;
  logic [debounce_pkg::IRQ_W-1:0] irq_event;
  logic count_read;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
    end
  end

  // Millisecond tick generator
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tick_cnt <= 17'h00000;
      cif.tick <= 1'b0;
    end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
      tick_cnt <= 17'h00000;
      cif.tick <= 1'b1; // One sample per ms
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      cif.tick <= 1'b0;
    end
  end

  assign cif.stable_ms = stable_ms;

  debounce_filter u_filter (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pin_sync(pin_sync),
    .bus(cif.core)
  );

  // Control register writes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      invert <= 1'b0;
      o_pullup_en <= 1'b0;
      stable_ms <= debounce_pkg::STABLE_MS_RESET;
    end else if (i_wr && i_addr == debounce_pkg::ADDR_CTRL) begin
      invert <= i_wdata[debounce_pkg::CTRL_INVERT_BIT];
      o_pullup_en <= i_wdata[debounce_pkg::CTRL_PULLUP_BIT];
      stable_ms <= i_wdata[debounce_pkg::CTRL_STABLE_LSB +: debounce_pkg::CTRL_STABLE_W];
    end
  end

  // Reported sense, optionally inverted
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else begin
      o_level <= cif.level ^ invert;
    end
  end

  assign count_read = i_rd && i_addr == debounce_pkg::ADDR_COUNT;

  // Transition counter; a change in the read cycle survives the clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      trans_count <= 16'h0000;
    end else if (count_read) begin
      trans_count <= cif.changed ? 16'h0001 : 16'h0000;
    end else if (cif.changed) begin
      trans_count <= trans_count + 16'h0001;
    end
  end

  // Time in present state, saturating so it never wraps to a short value
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      duration_ms <= 32'h0000_0000;
    end else if (cif.changed) begin
      duration_ms <= 32'h0000_0000;
    end else if (cif.tick && duration_ms != 32'hFFFF_FFFF) begin
      duration_ms <= duration_ms + 32'h0000_0001;
    end
  end

  // Sticky edge flags, write one to clear, set wins
  assign irq_event = {cif.changed & ~cif.level, cif.changed & cif.level};
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_status <= '0;
    end else if (i_wr && i_addr == debounce_pkg::ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~i_wdata[debounce_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_mask <= '0;
    end else if (i_wr && i_addr == debounce_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= i_wdata[debounce_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        debounce_pkg::ADDR_CTRL: o_rdata <= {16'h0000, stable_ms, 6'h00, o_pullup_en, invert};
        debounce_pkg::ADDR_STATUS: o_rdata <= {30'h0, cif.level, o_level};
        debounce_pkg::ADDR_COUNT: o_rdata <= {16'h0000, trans_count};
        debounce_pkg::ADDR_DURATION: o_rdata <= duration_ms;
        debounce_pkg::ADDR_IRQ_STATUS: o_rdata <= {30'h0, irq_status};
        debounce_pkg::ADDR_IRQ_MASK: o_rdata <= {30'h0, irq_mask};
        default: o_rdata <= debounce_pkg::UNMAPPED_READ;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule // debounced_switch_input

// file: debounce_pkg.sv
// Package with register map, field positions, reset values and timing counts
// Overview of operation
// - Sample the pin once per millisecond tick
// - Report new level after configurable stable time
// - Count each debounced level change
// - Millisecond duration in state, restarts on change
// - Inversion reports true while pin low
// - Optional internal pull-up enable output
package debounce_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int unsigned SAMPLE_RATE_HZ = 1000;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_DURATION = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam int CTRL_INVERT_BIT = 0;
  localparam int CTRL_PULLUP_BIT = 1;
  localparam int CTRL_STABLE_LSB = 8;
  localparam int CTRL_STABLE_W = 8;
  localparam logic [7:0] STABLE_MS_RESET = 8'h0A;
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// file: debounce_core_if.sv
// Interface between register front end and debounce filter
interface debounce_core_if;
  logic tick;
  logic [7:0] stable_ms;
  logic level;
  logic changed;
  modport ctrl (output tick, output stable_ms, input level, input changed);
  modport core (input tick, input stable_ms, output level, output changed);
endinterface

// file: debounce_filter.sv
// Debounce filter: stable-time counter and settled level
module debounce_filter (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_pin_sync,
  debounce_core_if.core bus
);
  logic [7:0] stable_cnt;
  logic sample;

  // Sample taken only on the millisecond tick
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sample <= 1'b1;
    end else if (bus.tick) begin
      sample <= i_pin_sync;
    end
  end

  // Count consecutive ticks that disagree with the settled level
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stable_cnt <= 8'h00;
      bus.level <= 1'b1;
      bus.changed <= 1'b0;
    end else begin
      bus.changed <= 1'b0;
      if (bus.tick) begin
        if (sample == bus.level) begin
          stable_cnt <= 8'h00; // Short excursion discarded
        end else if (stable_cnt + 8'h01 >= bus.stable_ms) begin
          bus.level <= sample;
          bus.changed <= 1'b1;
          stable_cnt <= 8'h00;
        end else begin
          stable_cnt <= stable_cnt + 8'h01;
        end
      end
    end
  end
endmodule // debounce_filter

// file: debounce_monitor.sv
// Checker of register port, pull-up and interrupt behaviour
module debounce_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_pullup_en,
  input wire logic o_level,
  input wire logic o_irq
);
  localparam logic [3:0] CT = debounce_pkg::ADDR_CTRL;
  localparam logic [3:0] MK = debounce_pkg::ADDR_IRQ_MASK;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Bus sequences of one and two steps
  sequence s_wctl; i_wr && i_addr == CT; endsequence
  sequence s_wrd; s_wctl ##1 i_rd && i_addr == CT && !i_wr; endsequence
  sequence s_mask0; i_wr && i_addr == MK && i_wdata[1:0] == 2'h0 ##1 !(i_wr && i_addr == MK);
  endsequence
  property p_pu_set; s_wctl |=> o_pullup_en == $past(i_wdata[1]); endproperty
  a_pu_set: assert property (p_pu_set) else $error("pull-up not set");
  property p_pu_hold; !(i_wr && i_addr == CT) |=> $stable(o_pullup_en); endproperty
  a_pu_hold: assert property (p_pu_hold) else $error("pull-up moved");
  property p_rb; s_wrd |=> o_rdata[15:8] == $past(i_wdata[15:8], 2); endproperty
  a_rb: assert property (p_rb) else $error("stable time readback");
  property p_irq_off; s_mask0 |=> !o_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq high");
  property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_unmap; i_rd && i_addr > MK |=> o_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_stat; i_rd && i_addr == debounce_pkg::ADDR_STATUS ##1 $stable(o_level)
    |-> o_rdata[0] == o_level; endproperty
  a_stat: assert property (p_stat) else $error("status level");
endmodule // debounce_monitor
bind debounced_switch_input debounce_monitor i_debounce_monitor (.*);

// file: switch_model.sv
// Push button to ground, pin floats without pull-up
module switch_model (
  input wire logic i_ref_clk,
  input wire logic i_pullup_en,
  input wire logic i_pressed,
  output logic o_pin
);
  // Floating pin toggles so a missing pull-up cannot pass for high
  always_ff @(posedge i_ref_clk) begin
    o_pin <= i_pressed ? 1'b0 : (i_pullup_en ? 1'b1 : (o_pin !== 1'b1));
  end
endmodule // switch_model

// file: tb_top.sv
// Testbench for the debounced switch input
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, press = 0, pin, pu, lvl, irq;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  int miscompares = 0, check_count = 0;
  // Short tick keeps the run well under the cycle budget
  debounced_switch_input #(.TICK_CYCLES(1000)) i_debounced_switch_input (.i_ref_clk(clk),
    .i_rst(rst), .i_pin(pin),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_pullup_en(pu),
    .o_level(lvl), .o_irq(irq));
  switch_model i_switch_model (.i_ref_clk(clk), .i_pullup_en(pu), .i_pressed(press), .o_pin(pin));
  // Free-running clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdat, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset();
    rd_reg("ctrl", debounce_pkg::ADDR_CTRL, 32'h0000_0A00);
    chk("pullup", {31'h0, pu}, 32'h0);
    chk("level", {31'h0, lvl}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_ctrl();
    wr_reg(debounce_pkg::ADDR_CTRL, 32'h0000_0103);
    repeat (2) @(posedge clk);
    #1 chk("pullup", {31'h0, pu}, 32'h1);
    chk("inverted", {31'h0, lvl}, 32'h0);
    rd_reg("ctrl rb", debounce_pkg::ADDR_CTRL, 32'h0000_0103);
    rd_reg("status", debounce_pkg::ADDR_STATUS, 32'h0000_0002);
    rd_reg("unmapped", 4'hF, 32'h0);
    wr_reg(debounce_pkg::ADDR_CTRL, 32'h0000_0102);
    repeat (2) @(posedge clk);
    #1 chk("plain", {31'h0, lvl}, 32'h1);
    $display("ctrl test done");
  endtask
  // Press waits out one 1000-cycle tick (stable time 1), so the run lasts one to two ticks
  task automatic t_press();
    int n;
    wr_reg(debounce_pkg::ADDR_IRQ_MASK, 32'h3);
    press <= 1'b1;
    for (n = 0; n < 5000 && lvl !== 1'b0; n++) @(posedge clk);
    if (n >= 5000) begin
      miscompares++;
      print_verdict();
    end
    chk("tick wait", {31'h0, n >= 1000 && n <= 2100}, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq", {31'h0, irq}, 32'h1);
    rd_reg("count", debounce_pkg::ADDR_COUNT, 32'h1);
    rd_reg("count clr", debounce_pkg::ADDR_COUNT, 32'h0);
    rd_reg("duration", debounce_pkg::ADDR_DURATION, 32'h0);
    rd_reg("irq stat", debounce_pkg::ADDR_IRQ_STATUS, 32'h2);
    wr_reg(debounce_pkg::ADDR_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    #1 chk("irq clr", {31'h0, irq}, 32'h0);
    $display("press test done");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_press();
    print_verdict();
  end
endmodule // tb_top
